// File: rtl/sensor_i2c_target.sv
// Function
// - Answers only at seven-bit address 7Fh
// - Controller opens each transfer with START
// - Controller closes each transfer with STOP
// - Address bit eight zero means write
// - Address bit eight one means read
// - Byte after write address loads pointer
// - Read uses repeated START then read address
// - First read byte comes from pointer
// - Pointer advances after each read byte
// - Controller acknowledges bytes to keep reading
// - Controller ends reading with STOP
// - Data byte stored at pointer register; only 2Ch stores it, at 03h a one in bit zero clears the error flag
// - Pointer advances after each written byte
// - Controller ends writing with STOP
// - Humidity code is ten bits wide
// - Temperature code is eleven bits wide
// - Humidity low byte then upper two bits
// - Temperature low byte then upper three bits
// - Four-bit internal capacitance select field
`timescale 1ns/1ps
module sensor_i2c_target
  import sensor_i2c_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // Bus side
  sensor_bus_if.device       bus,
  // Measurement results
  input  wire logic [9:0]    humidity_code,
  input  wire logic [10:0]   temperature_code,
  input  wire logic [15:0]   raw_capacitance,
  input  wire logic          manual_detect_error_set,
  // Control outputs
  output logic               reference_cap_connect,
  output logic [3:0]         internal_cap_select,
  output logic               manual_detect_error
);

  // ==========================================================
  // State
  dev_state_type  state_q;        // Byte engine state
  byte_kind_type  kind_q;         // Meaning of byte in flight
  logic [3:0]     cnt_q;          // Bits received or sent
  logic [7:0]     shift_q;        // Byte shift register
  logic [7:0]     ptr_q;          // Register pointer
  logic           rw_q;           // Direction of transfer
  logic           nack_q;         // Controller refused last byte
  logic           sda_oe_n_q;     // Data line pull enable
  logic           sda_o_q;        // Data line level when pulled
  logic           scl_q;          // Previous clock line level
  logic           sda_q;          // Previous data line level
  logic           err_q;          // Manual detection error flag
  logic           ref_cap_q;      // Reference capacitance on
  logic [3:0]     int_cap_q;      // Internal capacitance steps

  // ==========================================================
  // Line events
  wire logic scl_rise   = bus.scl & ~scl_q;
  wire logic scl_fall   = ~bus.scl & scl_q;
  wire logic start_cond = bus.scl & scl_q & sda_q & ~bus.sda;
  wire logic stop_cond  = bus.scl & scl_q & ~sda_q & bus.sda;
  wire logic byte_done  = scl_fall & (cnt_q == BYTE_BITS);

  // ==========================================================
  // Decode of received bytes
  wire logic addr_hit   = (shift_q[7:1] == DEVICE_BUS_ADDRESS);
  wire logic wr_strobe  = (state_q == D_RX) & (kind_q == K_DATA) & byte_done;
  wire logic wr_err     = wr_strobe & (ptr_q == REG_ERROR);
  wire logic wr_cap     = wr_strobe & (ptr_q == REG_CAP_CTRL);
  wire logic err_clear  = wr_err & shift_q[ERR_BIT];

  // ==========================================================
  // Read data selection
  wire logic [7:0] rd_data =
    (ptr_q == REG_ERROR)    ? {7'h00, err_q} :
    (ptr_q == REG_HUM_LO)   ? humidity_code[7:0] :
    (ptr_q == REG_HUM_HI)   ? {6'h00, humidity_code[9:8]} :
    (ptr_q == REG_TEMP_LO)  ? temperature_code[7:0] :
    (ptr_q == REG_TEMP_HI)  ? {5'h00, temperature_code[10:8]} :
    (ptr_q == REG_RAW_LO)   ? raw_capacitance[7:0] :
    (ptr_q == REG_RAW_HI)   ? raw_capacitance[15:8] :
    (ptr_q == REG_CAP_CTRL) ? {3'h0, ref_cap_q, int_cap_q} :
                              8'h00;

  // ==========================================================
  // Line history for edge detection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  // ==========================================================
  // Error flag: a set in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      err_q <= ERR_RESET;
    else if (ce)
      err_q <= manual_detect_error_set | (err_q & ~err_clear);
  end

  // ==========================================================
  // Capacitance connection control register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ref_cap_q <= REF_CAP_RESET;
      int_cap_q <= INT_CAP_RESET;
    end
    else if (ce && wr_cap)
    begin
      ref_cap_q <= shift_q[REF_CAP_BIT];
      int_cap_q <= shift_q[INT_CAP_MSB:0];
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      reference_cap_connect <= REF_CAP_RESET;
      internal_cap_select   <= INT_CAP_RESET;
      manual_detect_error   <= ERR_RESET;
      sda_o_q               <= 1'b0;
    end
    else if (ce)
    begin
      reference_cap_connect <= ref_cap_q;
      internal_cap_select   <= int_cap_q;
      manual_detect_error   <= err_q;
      sda_o_q               <= 1'b0;
    end
  end

  assign bus.dev_sda_o    = sda_o_q;
  assign bus.dev_sda_oe_n = sda_oe_n_q;

  // ==========================================================
  // Byte engine
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q    <= D_IDLE;
      kind_q     <= K_ADDR;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= DIR_WRITE;
      nack_q     <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end
    else if (ce)
    begin
      if (stop_cond)
      begin
        // Release the line and wait for the next START
        state_q    <= D_IDLE;
        sda_oe_n_q <= 1'b1;
      end
      else if (start_cond)
      begin
        // Also a repeated START: pointer is kept
        state_q    <= D_RX;
        kind_q     <= K_ADDR;
        cnt_q      <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end
      else
      begin
        unique case (state_q)
          D_IDLE: ;
          D_RX:
          begin
            if (scl_rise)
            begin
              shift_q <= {shift_q[6:0], bus.sda};
              cnt_q   <= cnt_q + 4'h1;
            end
            else if (byte_done)
            begin
              if (kind_q != K_ADDR || addr_hit)
              begin
                // Pull the line low for the acknowledge bit
                state_q    <= D_ACK;
                sda_oe_n_q <= 1'b0;
              end
              else
                state_q <= D_IDLE;
              if (kind_q == K_ADDR)
                rw_q <= shift_q[0];
              if (kind_q == K_REG)
                ptr_q <= shift_q;
              if (kind_q == K_DATA)
                ptr_q <= ptr_q + 8'h01;
            end
          end
          D_ACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (kind_q == K_ADDR && rw_q == DIR_READ)
              begin
                // First read byte from the pointer
                state_q    <= D_TX;
                shift_q    <= rd_data;
                sda_oe_n_q <= rd_data[7];
                ptr_q      <= ptr_q + 8'h01;
              end
              else
              begin
                state_q    <= D_RX;
                sda_oe_n_q <= 1'b1;
                kind_q     <= (kind_q == K_ADDR) ? K_REG : K_DATA;
              end
            end
          end
          D_TX:
          begin
            if (scl_fall)
            begin
              if (cnt_q == BYTE_BITS - 4'h1)
              begin
                // Hand the line back for the acknowledge bit
                state_q    <= D_RACK;
                sda_oe_n_q <= 1'b1;
              end
              else
              begin
                shift_q    <= {shift_q[6:0], 1'b0};
                sda_oe_n_q <= shift_q[6];
                cnt_q      <= cnt_q + 4'h1;
              end
            end
          end
          D_RACK:
          begin
            if (scl_rise)
              nack_q <= bus.sda;
            else if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (nack_q)
                state_q <= D_IDLE;
              else
              begin
                // Acknowledged: supply the next register
                state_q    <= D_TX;
                shift_q    <= rd_data;
                sda_oe_n_q <= rd_data[7];
                ptr_q      <= ptr_q + 8'h01;
              end
            end
          end
          default:
            state_q <= D_IDLE;
        endcase
      end
    end
  end

endmodule // sensor_i2c_target

// File: common/sensor_i2c_pkg.sv
package sensor_i2c_pkg;

  // ==========================================================
  // Bus addressing
  localparam logic [6:0] DEVICE_BUS_ADDRESS = 7'h7F;
  localparam logic       DIR_WRITE          = 1'b0;
  localparam logic       DIR_READ           = 1'b1;
  localparam logic [3:0] BYTE_BITS          = 4'h8;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_ERROR    = 8'h03;
  localparam logic [7:0] REG_HUM_LO   = 8'h04;
  localparam logic [7:0] REG_HUM_HI   = 8'h05;
  localparam logic [7:0] REG_TEMP_LO  = 8'h06;
  localparam logic [7:0] REG_TEMP_HI  = 8'h07;
  localparam logic [7:0] REG_RAW_LO   = 8'h0A;
  localparam logic [7:0] REG_RAW_HI   = 8'h0B;
  localparam logic [7:0] REG_CAP_CTRL = 8'h2C;

  // ==========================================================
  // Field positions and reset values
  localparam int         ERR_BIT        = 0;
  localparam int         REF_CAP_BIT    = 4;
  localparam int         INT_CAP_MSB    = 3;
  localparam logic [3:0] INT_CAP_RESET  = 4'h0;
  localparam logic       REF_CAP_RESET  = 1'b0;
  localparam logic       ERR_RESET      = 1'b0;

  // ==========================================================
  // Timing: bus clock quarter period, least time, rounded up
  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         SCL_QUARTER_NS = 2500;
  localparam logic [6:0] QUARTER_CYCLES =
    7'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // State types
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX   = 3'h1,
    D_ACK  = 3'h3,
    D_TX   = 3'h2,
    D_RACK = 3'h6
  } dev_state_type;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_REG  = 2'h1,
    K_DATA = 2'h3
  } byte_kind_type;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h3,
    H_STOP  = 2'h2
  } host_state_type;

  typedef enum logic [2:0] {
    S_ADDR_W = 3'h0,
    S_REG    = 3'h1,
    S_WDATA  = 3'h3,
    S_ADDR_R = 3'h2,
    S_RDATA  = 3'h6
  } stage_type;

endpackage

// File: common/sensor_bus_if.sv
`timescale 1ns/1ps
interface sensor_bus_if;
  // Host drives the clock line
  logic host_scl_o;
  logic host_scl_oe_n;
  // Both ends may pull the data line low
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  // Resolved open-drain levels with pull-ups
  logic scl;
  logic sda;

  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                output host_sda_o, output host_sda_oe_n);
endinterface

// File: rtl/sensor_i2c_host.sv
`timescale 1ns/1ps
module sensor_i2c_host
  import sensor_i2c_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  // Bus side
  sensor_bus_if.host         bus,
  // Request port
  input  wire logic          req_valid,
  input  wire logic          req_read,
  input  wire logic [7:0]    req_reg,
  input  wire logic [3:0]    req_len,
  input  wire logic [7:0]    wr_byte,
  // Answer port
  output logic               busy,
  output logic               wr_take,
  output logic [7:0]         rd_byte,
  output logic               rd_valid,
  output logic               nack
);

  // ==========================================================
  // State
  host_state_type state_q;     // Line sequencer state
  stage_type      stage_q;     // Byte currently on the bus
  logic [6:0]     div_q;       // Quarter period divider
  logic [1:0]     quarter_q;   // Quarter within a bit
  logic [3:0]     bitn_q;      // Bit index, eight is acknowledge
  logic [7:0]     byte_q;      // Byte shift register
  logic [3:0]     rem_q;       // Data bytes still to move
  logic           read_q;      // Transfer is a read
  logic           samp_q;      // Sampled data line
  logic           scl_oe_n_q;  // Clock line pull enable
  logic           sda_oe_n_q;  // Data line pull enable

  // ==========================================================
  // Pacing and decode
  wire logic tick      = (state_q != H_IDLE) & (div_q == QUARTER_CYCLES - 7'h01);
  wire logic reading   = (stage_q == S_RDATA);
  wire logic last_byte = (rem_q <= 4'h1);

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = scl_oe_n_q;
  assign bus.host_sda_oe_n = sda_oe_n_q;

  // ==========================================================
  // Quarter period divider
  always_ff @(posedge clock)
  begin
    if (sys_rst || state_q == H_IDLE)
      div_q <= 7'h00;
    else if (ce)
      div_q <= tick ? 7'h00 : div_q + 7'h01;
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_q <= H_IDLE; stage_q <= S_ADDR_W; quarter_q <= 2'h0;
      bitn_q  <= 4'h0;   byte_q  <= 8'h00;    rem_q     <= 4'h0;
      read_q  <= 1'b0;   samp_q  <= 1'b1;     scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1; busy <= 1'b0; wr_take <= 1'b0;
      rd_byte <= 8'h00;  rd_valid <= 1'b0;    nack <= 1'b0;
    end
    else if (ce)
    begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      if (state_q == H_IDLE)
      begin
        if (req_valid)
        begin
          // Write address first, even for reads
          state_q   <= H_START;
          stage_q   <= S_ADDR_W;
          byte_q    <= {DEVICE_BUS_ADDRESS, DIR_WRITE};
          read_q    <= req_read;
          rem_q     <= (req_read && req_len == 4'h0) ? 4'h1 : req_len;
          quarter_q <= 2'h0;
          busy      <= 1'b1;
          nack      <= 1'b0;
        end
      end
      else if (tick)
      begin
        quarter_q <= quarter_q + 2'h1;
        unique case (state_q)
          H_START:
          begin
            // Data falls while the clock is high
            unique case (quarter_q)
              2'h0: sda_oe_n_q <= 1'b1;
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: sda_oe_n_q <= 1'b0;
              2'h3:
              begin
                scl_oe_n_q <= 1'b0;
                state_q    <= H_BIT;
                bitn_q     <= 4'h0;
              end
            endcase
          end
          H_BIT:
          begin
            unique case (quarter_q)
              2'h0:
                if (bitn_q < BYTE_BITS)
                  sda_oe_n_q <= reading | byte_q[7];
                else
                  sda_oe_n_q <= ~reading | last_byte;
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: samp_q <= bus.sda;
              2'h3:
              begin
                scl_oe_n_q <= 1'b0;
                if (bitn_q < BYTE_BITS)
                begin
                  byte_q <= {byte_q[6:0], samp_q};
                  bitn_q <= bitn_q + 4'h1;
                end
                else
                begin
                  bitn_q <= 4'h0;
                  if (!reading && samp_q)
                  begin
                    nack    <= 1'b1;
                    state_q <= H_STOP;
                  end
                  else
                    unique case (stage_q)
                      S_ADDR_W:
                      begin
                        stage_q <= S_REG;
                        byte_q  <= req_reg;
                      end
                      S_REG, S_WDATA:
                        if (read_q)
                        begin
                          // Repeated START, then read address
                          state_q <= H_START;
                          stage_q <= S_ADDR_R;
                          byte_q  <= {DEVICE_BUS_ADDRESS, DIR_READ};
                        end
                        else if (rem_q == 4'h0)
                          state_q <= H_STOP;
                        else
                        begin
                          stage_q <= S_WDATA;
                          byte_q  <= wr_byte;
                          wr_take <= 1'b1;
                          rem_q   <= rem_q - 4'h1;
                        end
                      S_ADDR_R:
                        stage_q <= S_RDATA;
                      S_RDATA:
                      begin
                        rd_byte  <= byte_q;
                        rd_valid <= 1'b1;
                        rem_q    <= rem_q - 4'h1;
                        if (last_byte)
                          state_q <= H_STOP;
                      end
                      default:
                        state_q <= H_STOP;
                    endcase
                end
              end
            endcase
          end
          H_STOP:
          begin
            // Data rises while the clock is high
            unique case (quarter_q)
              2'h0: sda_oe_n_q <= 1'b0;
              2'h1: scl_oe_n_q <= 1'b1;
              2'h2: sda_oe_n_q <= 1'b1;
              2'h3:
              begin
                state_q <= H_IDLE;
                busy    <= 1'b0;
              end
            endcase
          end
          default:
            state_q <= H_IDLE;
        endcase
      end
    end
  end

endmodule // sensor_i2c_host

// File: dv/sensor_i2c_assertions.sv
`timescale 1ns/1ps
module sensor_i2c_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Open-drain drives
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  // Resolved lines
  input wire logic scl,
  input wire logic sda
);
  // ==========================================================
  // Frame tracking
  logic       scl_q;      // Line levels one cycle back
  logic       sda_q;
  logic       in_frame_q; // Between START and STOP
  logic [3:0] nbit_q;     // Clock rises since last START
  wire start_seen = scl && scl_q && sda_q && !sda; // Data falls, clock high
  wire stop_seen  = scl && scl_q && !sda_q && sda; // Data rises, clock high
  wire scl_up     = scl && !scl_q;
  wire [3:0] nbit_d = start_seen ? 4'h0 : (scl_up && nbit_q != 4'hF) ? nbit_q + 4'h1 : nbit_q;

  // Registers the line history, saturating bit count
  always_ff @(posedge clock)
  begin
    scl_q      <= sys_rst | scl;
    sda_q      <= sys_rst | sda;
    in_frame_q <= !sys_rst && (start_seen || (in_frame_q && !stop_seen));
    nbit_q     <= sys_rst ? 4'h0 : nbit_d;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Line rules
  // Watches the reset itself, so the default disable is overridden here
  a_reset_released: assert property (@(posedge clock) disable iff (1'b0)
    sys_rst ##1 sys_rst |-> host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
    else $error("line pulled during reset");
  a_drive_low_only: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open-drain output not low");
  a_dev_sda_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("target moved data with clock high");
  a_dev_quiet_idle: assert property (!in_frame_q |-> dev_sda_oe_n)
    else $error("target pulled data outside a frame");
  a_idle_scl_high: assert property (!in_frame_q && !start_seen |-> scl)
    else $error("clock low outside a frame");
  a_addr_acked: assert property (scl_up && nbit_q == 4'h8 && in_frame_q |-> !dev_sda_oe_n)
    else $error("address byte not acknowledged");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");

  // Main scenarios
  c_start: cover property (start_seen);
  c_stop: cover property (stop_seen);
  c_ack: cover property (scl_up && nbit_q == 4'h8 && !sda);
  c_dev_data: cover property (scl_up && nbit_q > 4'h9 && !dev_sda_oe_n);
endmodule // sensor_i2c_checker

// File: dv/humidity_sensor_i2c_register_port_tb_top.sv
`timescale 1ns/1ps
module humidity_sensor_i2c_register_port_tb_top;
  import sensor_i2c_pkg::*;
  // ==========================================================
  // Stimulus and observation
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_read = 1'b0;
  logic [7:0]  req_reg = 8'h00;
  logic [3:0]  req_len = 4'h0;
  logic [7:0]  wr_byte = 8'h00;
  logic [9:0]  humidity_code = 10'h000;
  logic [10:0] temperature_code = 11'h000;
  logic [15:0] raw_capacitance = 16'h0000;
  logic        manual_detect_error_set = 1'b0;
  logic        busy, wr_take, rd_valid, nack;
  logic [7:0]  rd_byte;
  logic        reference_cap_connect, manual_detect_error;
  logic [3:0]  internal_cap_select;
  logic [7:0]  wq[$];       // Bytes still to write
  logic [7:0]  rq[$];       // Bytes read back
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;

  // Clock at 25 MHz
  always #20 clock = ~clock;

  // ==========================================================
  // Both ends joined by the bus
  sensor_bus_if u_bus ();
  sensor_i2c_target u_sensor_i2c_target (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus(u_bus),
    .humidity_code(humidity_code), .temperature_code(temperature_code), .raw_capacitance(raw_capacitance),
    .manual_detect_error_set(manual_detect_error_set), .reference_cap_connect(reference_cap_connect),
    .internal_cap_select(internal_cap_select), .manual_detect_error(manual_detect_error));
  sensor_i2c_host u_sensor_i2c_host (.clock(clock), .sys_rst(sys_rst), .ce(ce), .bus(u_bus),
    .req_valid(req_valid), .req_read(req_read), .req_reg(req_reg), .req_len(req_len), .wr_byte(wr_byte),
    .busy(busy), .wr_take(wr_take), .rd_byte(rd_byte), .rd_valid(rd_valid), .nack(nack));
  sensor_i2c_checker u_sensor_i2c_checker (.clock(clock), .sys_rst(sys_rst),
    .host_scl_o(u_bus.host_scl_o), .host_scl_oe_n(u_bus.host_scl_oe_n), .host_sda_o(u_bus.host_sda_o),
    .host_sda_oe_n(u_bus.host_sda_oe_n), .dev_sda_o(u_bus.dev_sda_o), .dev_sda_oe_n(u_bus.dev_sda_oe_n),
    .scl(u_bus.scl), .sda(u_bus.sda));

  // ==========================================================
  // Shared tasks
  task automatic results();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares one value and reports a mismatch
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request; feeds write bytes on each take, gathers read bytes
  task automatic xfer(input logic rd, input logic [7:0] rg, input logic [3:0] len);
    logic seen;
    logic take;
    seen = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_read  <= rd;
    req_reg   <= rg;
    req_len   <= len;
    wr_byte   <= (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (40000)
    begin
      @(negedge clock);
      take = (wr_take === 1'b1);
      if (rd_valid === 1'b1)
        rq.push_back(rd_byte);
      if (busy === 1'b1)
        seen = 1'b1;
      else if (seen)
        break;
      @(posedge clock);
      // Next write byte once the current one is taken
      if (take && wq.size() > 0)
      begin
        void'(wq.pop_front());
        wr_byte <= (wq.size() > 0) ? wq[0] : 8'h00;
      end
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    @(negedge clock);
    check("busy", busy, 1'b0);
    check("nack", nack, 1'b0);
    check("ref cap", reference_cap_connect, REF_CAP_RESET);
    check("int cap", internal_cap_select, INT_CAP_RESET);
    check("error", manual_detect_error, ERR_RESET);
  endtask

  // Two bytes from an unmapped place into the control register
  task automatic test_write_span();
    wq = '{8'h55, 8'hFA};
    xfer(DIR_WRITE, 8'h2B, 4'h2);
    check("wr nack", nack, 1'b0);
    check("ref cap", reference_cap_connect, 1'b1);
    check("int cap", internal_cap_select, 4'hA);
    rq.delete();
    xfer(DIR_READ, REG_CAP_CTRL, 4'h1);
    check("ctrl count", 16'(rq.size()), 16'h0001);
    check("ctrl read", rq[0], 8'h1A);
  endtask

  // Error flag then results, nine bytes in a row
  task automatic test_read_results();
    logic [7:0] exp [9];
    exp = '{8'h01, 8'hA5, 8'h02, 8'hC3, 8'h05, 8'h00, 8'h00, 8'h3E, 8'h9C};
    @(posedge clock);
    humidity_code <= 10'h2A5;
    temperature_code <= 11'h5C3;
    raw_capacitance <= 16'h9C3E;
    manual_detect_error_set <= 1'b1;
    @(posedge clock);
    manual_detect_error_set <= 1'b0;
    repeat (3) @(negedge clock);
    check("error set", manual_detect_error, 1'b1);
    rq.delete();
    xfer(DIR_READ, REG_ERROR, 4'h9);
    check("rd nack", nack, 1'b0);
    check("rd count", 16'(rq.size()), 16'h0009);
    for (int i = 0; i < 9; i++)
      check("result byte", rq[i], exp[i]);
  endtask

  // Writing one clears the error flag
  task automatic test_error_clear();
    wq = '{8'h01};
    xfer(DIR_WRITE, REG_ERROR, 4'h1);
    repeat (3) @(negedge clock);
    check("error clear", manual_detect_error, 1'b0);
  endtask

  // Enable low freezes the error flag against a set pulse
  task automatic test_ce_freeze();
    @(posedge clock);
    ce <= 1'b0;
    manual_detect_error_set <= 1'b1;
    @(posedge clock);
    manual_detect_error_set <= 1'b0;
    @(posedge clock);
    ce <= 1'b1;
    repeat (3) @(negedge clock);
    check("frozen error", manual_detect_error, 1'b0);
  endtask

  // ==========================================================
  // Cuts a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      error_cnt++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_write_span();
    test_read_results();
    test_error_clear();
    test_ce_freeze();
    results();
  end
endmodule // humidity_sensor_i2c_register_port_tb_top
